// >>> hw/ser_consts.svh
// constants for the status event reporting block
// Overview of operation
// [RULE1] operation condition: bit 8 voltage, 10 current regulation
// [RULE2] bits 11,12,14,9: sample, list done, running, transient
// [RULE3] bit 6 armed, 5 awaiting trigger; others zero
// [RULE4] summary bit 7 is OR of enabled operation events
// [RULE5] operation mask query returns stored mask value
// [RULE6] operation events latched; read returns then clears
// [RULE7] preset loads masks with 8193 and 255
// [RULE8] questionable: thermal 3, voltage 12, current 13, follower 6
// [RULE9] questionable: mode errors at bits 0, 1
// [RULE10] questionable bit 14 set while sinking energy
// [RULE11] only questionable bits 13 and 12 latch events
// [RULE12] questionable events read returns value then clears
// [RULE13] questionable condition shows live unlatched state
// [RULE14] summary bit 3 is OR of enabled questionable events
// [RULE15] questionable mask query returns stored mask value
// [RULE16] operation condition shows live unlatched operating state
// [RULE17] operation event set on condition rising edge
`ifndef SER_CONSTS_SVH
`define SER_CONSTS_SVH

// ****************************************
// operation word bit positions
// ****************************************
`define SER_OP_AWAIT_TRIG_BIT 5
`define SER_OP_ARMED_BIT 6
`define SER_OP_CV_BIT 8
`define SER_OP_TRANS_DONE_BIT 9
`define SER_OP_CC_BIT 10
`define SER_OP_SAMPLE_DONE_BIT 11
`define SER_OP_LIST_DONE_BIT 12
`define SER_OP_LIST_RUN_BIT 14

// ****************************************
// questionable word bit positions
// ****************************************
`define SER_QU_VMODE_ERR_BIT 0
`define SER_QU_CMODE_ERR_BIT 1
`define SER_QU_THERMAL_BIT 3
`define SER_QU_FOLLOWER_BIT 6
`define SER_QU_VERR_BIT 12
`define SER_QU_CERR_BIT 13
`define SER_QU_ENERGY_ABSORBING_FLAG_BIT 14
`define SER_QU_LATCH_MASK 16'h3000

// ****************************************
// reset and preset values, summary bit positions
// ****************************************
`define SER_OP_ENA_PRESET 16'h2001
`define SER_QU_ENA_PRESET 16'h00FF
`define SER_OP_ENA_RESET 16'h0000
`define SER_QU_ENA_RESET 16'h0000
`define SER_SB_OPER_BIT 7
`define SER_SB_QUES_BIT 3

// ****************************************
// register selector codes for the query port
// ****************************************
`define SER_SEL_OP_COND 3'h0
`define SER_SEL_OP_ENA 3'h1
`define SER_SEL_OP_EVT 3'h2
`define SER_SEL_QU_COND 3'h3
`define SER_SEL_QU_ENA 3'h4
`define SER_SEL_QU_EVT 3'h5

`endif

// >>> hw/ser_event_latch.sv
// sticky event latch with clear-on-read and masked summary
`timescale 1ns/1ns
`include "ser_consts.svh"

module ser_event_latch (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [15:0] cond,
    input wire logic [15:0] latch_mask,
    input wire logic [15:0] ena,
    input wire logic rd_clr,
    output logic [15:0] evt_r,
    output logic summary_r
);

    logic [15:0] prev_r;
    logic [15:0] prev_nxt;
    logic [15:0] evt_nxt;
    logic [15:0] rise;
    logic summary_nxt;

    // rising edges set events; a new edge in the read cycle survives
    always_comb begin
        rise = cond & ~prev_r & latch_mask;
        prev_nxt = cond;
        evt_nxt = (rd_clr ? 16'h0000 : evt_r) | rise; // RULE17 RULE6
        summary_nxt = |(evt_nxt & ena); // RULE4 RULE14
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prev_r <= 16'h0000;
            evt_r <= 16'h0000;
            summary_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
            evt_r <= evt_nxt;
            summary_r <= summary_nxt;
        end
    end

    property p_evt_sticky;
        @(posedge clk_sys) disable iff (!arst_n)
        (!rd_clr) |=> ((evt_r & $past(evt_r)) == $past(evt_r));
    endproperty
    a_evt_sticky: assert property (p_evt_sticky) // RULE6
        else $error("event bit lost without a read");

    property p_evt_masked;
        @(posedge clk_sys) disable iff (!arst_n)
        (evt_r & ~latch_mask) == 16'h0000;
    endproperty
    a_evt_masked: assert property (p_evt_masked) // RULE11
        else $error("event latched outside latch mask");

    property p_evt_rise;
        @(posedge clk_sys) disable iff (!arst_n)
        ((cond & ~$past(cond) & latch_mask) != 16'h0000) |=>
            ((~evt_r & $past(cond) & ~$past(cond, 2) & latch_mask)
                == 16'h0000);
    endproperty
    a_evt_rise: assert property (p_evt_rise) // RULE17
        else $error("rising condition did not set event");

endmodule

// >>> hw/ser_pkg.sv
// types for the status event reporting block
package ser_pkg;

    // live operating state from the regulation and sequencer logic
    typedef struct packed {
        logic constant_voltage_flag;
        logic constant_current_flag;
        logic transient_complete_flag;
        logic sample_complete_flag;
        logic list_complete_flag;
        logic list_running_flag;
        logic transient_armed_flag;
        logic awaiting_trigger_flag;
    } ser_op_state_t;

    // live questionable state
    typedef struct packed {
        logic voltage_regulation_error_flag;
        logic current_regulation_error_flag;
        logic thermal_error_flag;
        logic follower_unit_error_flag;
        logic voltage_error_flag;
        logic current_error_flag;
        logic energy_absorbing_flag;
    } ser_qu_state_t;

    // one command or query from the message parser
    typedef struct packed {
        logic valid;
        logic write;
        logic preset;
        logic [2:0] sel;
        logic [15:0] data;
    } ser_cmd_t;

    typedef enum logic [1:0] {
        SER_IDLE = 2'b01,
        SER_RESP = 2'b10
    } ser_state_t;

endpackage

// >>> hw/ser_status_regs.sv
// status reporting registers: condition, event, enable for two groups
`timescale 1ns/1ns
`include "ser_consts.svh"

module ser_status_regs (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire ser_pkg::ser_op_state_t op_state,
    input wire ser_pkg::ser_qu_state_t qu_state,
    input wire ser_pkg::ser_cmd_t cmd,
    output logic resp_valid_r,
    output logic [15:0] resp_data_r,
    output logic oper_summary_r,
    output logic ques_summary_r
);

    // ****************************************
    // input synchronisers
    // ****************************************
    // status lines come from analog comparators and other logic, so treat
    // them as asynchronous; the first stage feeds only the second
    ser_pkg::ser_op_state_t op_s1_r;
    ser_pkg::ser_op_state_t op_s2_r;
    ser_pkg::ser_qu_state_t qu_s1_r;
    ser_pkg::ser_qu_state_t qu_s2_r;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            op_s1_r <= '0;
            op_s2_r <= '0;
            qu_s1_r <= '0;
            qu_s2_r <= '0;
        end else begin
            op_s1_r <= op_state;
            op_s2_r <= op_s1_r;
            qu_s1_r <= qu_state;
            qu_s2_r <= qu_s1_r;
        end
    end

    // ****************************************
    // live condition words
    // ****************************************
    logic [15:0] op_cond;
    logic [15:0] qu_cond;

    // unused positions stay tied low so they always read zero
    always_comb begin
        op_cond = 16'h0000;
        op_cond[`SER_OP_CV_BIT] = op_s2_r.constant_voltage_flag; // RULE1
        op_cond[`SER_OP_CC_BIT] = op_s2_r.constant_current_flag; // RULE1
        op_cond[`SER_OP_TRANS_DONE_BIT] =
            op_s2_r.transient_complete_flag; // RULE2
        op_cond[`SER_OP_SAMPLE_DONE_BIT] =
            op_s2_r.sample_complete_flag; // RULE2
        op_cond[`SER_OP_LIST_DONE_BIT] =
            op_s2_r.list_complete_flag; // RULE2
        op_cond[`SER_OP_LIST_RUN_BIT] = op_s2_r.list_running_flag; // RULE2
        op_cond[`SER_OP_ARMED_BIT] = op_s2_r.transient_armed_flag; // RULE3
        op_cond[`SER_OP_AWAIT_TRIG_BIT] =
            op_s2_r.awaiting_trigger_flag; // RULE3
    end

    // both mode-error bits may be high together while output settles
    always_comb begin
        qu_cond = 16'h0000;
        qu_cond[`SER_QU_VMODE_ERR_BIT] =
            qu_s2_r.voltage_regulation_error_flag; // RULE9 RULE13
        qu_cond[`SER_QU_CMODE_ERR_BIT] =
            qu_s2_r.current_regulation_error_flag; // RULE9 RULE13
        qu_cond[`SER_QU_THERMAL_BIT] = qu_s2_r.thermal_error_flag; // RULE8
        qu_cond[`SER_QU_FOLLOWER_BIT] =
            qu_s2_r.follower_unit_error_flag; // RULE8
        qu_cond[`SER_QU_VERR_BIT] = qu_s2_r.voltage_error_flag; // RULE8
        qu_cond[`SER_QU_CERR_BIT] = qu_s2_r.current_error_flag; // RULE8
        qu_cond[`SER_QU_ENERGY_ABSORBING_FLAG_BIT] = qu_s2_r.energy_absorbing_flag; // RULE10
    end

    // ****************************************
    // enable masks and preset
    // ****************************************
    logic [15:0] op_ena_r;
    logic [15:0] op_ena_nxt;
    logic [15:0] qu_ena_r;
    logic [15:0] qu_ena_nxt;

    // preset wins over a mask write issued in the same command
    always_comb begin
        op_ena_nxt = op_ena_r;
        qu_ena_nxt = qu_ena_r;
        if (cmd.valid && cmd.preset) begin
            op_ena_nxt = `SER_OP_ENA_PRESET; // RULE7
            qu_ena_nxt = `SER_QU_ENA_PRESET; // RULE7
        end else if (cmd.valid && cmd.write) begin
            if (cmd.sel == `SER_SEL_OP_ENA) begin
                op_ena_nxt = cmd.data;
            end
            if (cmd.sel == `SER_SEL_QU_ENA) begin
                qu_ena_nxt = cmd.data;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            op_ena_r <= `SER_OP_ENA_RESET;
            qu_ena_r <= `SER_QU_ENA_RESET;
        end else begin
            op_ena_r <= op_ena_nxt;
            qu_ena_r <= qu_ena_nxt;
        end
    end

    // ****************************************
    // event latches
    // ****************************************
    logic is_query;
    logic op_rd;
    logic qu_rd;
    logic [15:0] op_evt;
    logic [15:0] qu_evt;

    always_comb begin
        is_query = cmd.valid && !cmd.write && !cmd.preset;
        op_rd = is_query && (cmd.sel == `SER_SEL_OP_EVT); // RULE6
        qu_rd = is_query && (cmd.sel == `SER_SEL_QU_EVT); // RULE12
    end

    ser_event_latch u_op_evt (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .cond(op_cond),
        .latch_mask(16'hFFFF),
        .ena(op_ena_nxt),
        .rd_clr(op_rd),
        .evt_r(op_evt),
        .summary_r(oper_summary_r)
    );

    // only current and voltage errors are latched
    ser_event_latch u_qu_evt (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .cond(qu_cond),
        .latch_mask(`SER_QU_LATCH_MASK), // RULE11
        .ena(qu_ena_nxt),
        .rd_clr(qu_rd),
        .evt_r(qu_evt),
        .summary_r(ques_summary_r)
    );

    // ****************************************
    // query responder
    // ****************************************
    ser_pkg::ser_state_t state_r;
    ser_pkg::ser_state_t state_nxt;
    logic resp_valid_nxt;
    logic [15:0] resp_data_nxt;

    // event value is captured before the clear lands, one cycle answer
    always_comb begin
        state_nxt = ser_pkg::SER_IDLE;
        resp_valid_nxt = 1'b0;
        resp_data_nxt = resp_data_r;
        unique case (state_r)
            ser_pkg::SER_IDLE,
            ser_pkg::SER_RESP: begin
                if (is_query) begin
                    state_nxt = ser_pkg::SER_RESP;
                    resp_valid_nxt = 1'b1;
                    unique case (cmd.sel)
                        `SER_SEL_OP_COND: resp_data_nxt = op_cond; // RULE16
                        `SER_SEL_OP_ENA: resp_data_nxt = op_ena_r; // RULE5
                        `SER_SEL_OP_EVT: resp_data_nxt = op_evt; // RULE6
                        `SER_SEL_QU_COND: resp_data_nxt = qu_cond; // RULE13
                        `SER_SEL_QU_ENA: resp_data_nxt = qu_ena_r; // RULE15
                        `SER_SEL_QU_EVT: resp_data_nxt = qu_evt; // RULE12
                        default: resp_data_nxt = 16'h0000;
                    endcase
                end
            end
            default: state_nxt = ser_pkg::SER_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ser_pkg::SER_IDLE;
            resp_valid_r <= 1'b0;
            resp_data_r <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            resp_valid_r <= resp_valid_nxt;
            resp_data_r <= resp_data_nxt;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_preset;
        @(posedge clk_sys) disable iff (!arst_n)
        (cmd.valid && cmd.preset) |=>
            (op_ena_r == 16'h2001 && qu_ena_r == 16'h00FF);
    endproperty
    a_preset: assert property (p_preset) // RULE7
        else $error("preset did not load masks");

    property p_oper_sum;
        @(posedge clk_sys) disable iff (!arst_n)
        oper_summary_r == |(op_evt & op_ena_r);
    endproperty
    a_oper_sum: assert property (p_oper_sum) // RULE4
        else $error("operation summary mismatch");

    property p_ques_sum;
        @(posedge clk_sys) disable iff (!arst_n)
        ques_summary_r == |(qu_evt & qu_ena_r);
    endproperty
    a_ques_sum: assert property (p_ques_sum) // RULE14
        else $error("questionable summary mismatch");

    property p_op_unused;
        @(posedge clk_sys) disable iff (!arst_n)
        (op_cond & 16'hA09F) == 16'h0000;
    endproperty
    a_op_unused: assert property (p_op_unused) // RULE3
        else $error("unused operation bit set");

    property p_op_read_clear;
        @(posedge clk_sys) disable iff (!arst_n)
        op_rd |=> (resp_valid_r && resp_data_r == $past(op_evt));
    endproperty
    a_op_read_clear: assert property (p_op_read_clear) // RULE6
        else $error("operation event read returned wrong value");

    property p_qu_read_clear;
        @(posedge clk_sys) disable iff (!arst_n)
        (qu_rd && !$rose(qu_cond[13]) && !$rose(qu_cond[12])) |=>
            (qu_evt == 16'h0000);
    endproperty
    a_qu_read_clear: assert property (p_qu_read_clear) // RULE12
        else $error("questionable event not cleared by read");

    property p_cv_live;
        @(posedge clk_sys) disable iff (!arst_n)
        op_cond[8] == $past(op_state.constant_voltage_flag, 2) &&
            op_cond[10] == $past(op_state.constant_current_flag, 2);
    endproperty
    a_cv_live: assert property (p_cv_live) // RULE1
        else $error("regulation flags misplaced");

    property p_energy_absorbing_flag;
        @(posedge clk_sys) disable iff (!arst_n)
        $rose(qu_state.energy_absorbing_flag) |-> ##2 qu_cond[14];
    endproperty
    a_energy_absorbing_flag: assert property (p_energy_absorbing_flag) // RULE10
        else $error("energy_absorbing_flag flag not reported");

    property p_qu_unused;
        @(posedge clk_sys) disable iff (!arst_n)
        (qu_cond & 16'h8FB4) == 16'h0000;
    endproperty
    a_qu_unused: assert property (p_qu_unused) // RULE9
        else $error("unused questionable bit set");

    // live view: two sync stages, no latching in between
    property p_qu_live;
        @(posedge clk_sys) disable iff (!arst_n)
        qu_cond[12] == $past(qu_state.voltage_error_flag, 2) &&
            qu_cond[13] == $past(qu_state.current_error_flag, 2);
    endproperty
    a_qu_live: assert property (p_qu_live) // RULE13
        else $error("questionable condition not live");

    property p_qu_read_value;
        @(posedge clk_sys) disable iff (!arst_n)
        qu_rd |=> (resp_valid_r && resp_data_r == $past(qu_evt));
    endproperty
    a_qu_read_value: assert property (p_qu_read_value) // RULE12
        else $error("questionable event read returned wrong value");

    property p_op_clear;
        @(posedge clk_sys) disable iff (!arst_n)
        (op_rd && ((op_cond & ~$past(op_cond)) == 16'h0000)) |=>
            (op_evt == 16'h0000);
    endproperty
    a_op_clear: assert property (p_op_clear) // RULE6
        else $error("operation event not cleared by read");

    property p_op_ena_wr;
        @(posedge clk_sys) disable iff (!arst_n)
        (cmd.valid && cmd.write && !cmd.preset &&
            cmd.sel == `SER_SEL_OP_ENA) |=> (op_ena_r == $past(cmd.data));
    endproperty
    a_op_ena_wr: assert property (p_op_ena_wr) // RULE5
        else $error("operation mask write not stored");

    property p_qu_ena_wr;
        @(posedge clk_sys) disable iff (!arst_n)
        (cmd.valid && cmd.write && !cmd.preset &&
            cmd.sel == `SER_SEL_QU_ENA) |=> (qu_ena_r == $past(cmd.data));
    endproperty
    a_qu_ena_wr: assert property (p_qu_ena_wr) // RULE15
        else $error("questionable mask write not stored");

    property p_op_ena_query;
        @(posedge clk_sys) disable iff (!arst_n)
        (is_query && cmd.sel == `SER_SEL_OP_ENA) |=>
            (resp_data_r == $past(op_ena_r));
    endproperty
    a_op_ena_query: assert property (p_op_ena_query) // RULE5
        else $error("operation mask query returned wrong value");

    property p_qu_ena_query;
        @(posedge clk_sys) disable iff (!arst_n)
        (is_query && cmd.sel == `SER_SEL_QU_ENA) |=>
            (resp_data_r == $past(qu_ena_r));
    endproperty
    a_qu_ena_query: assert property (p_qu_ena_query) // RULE15
        else $error("questionable mask query returned wrong value");

endmodule

// >>> verif/ser_host_model.sv
// host controller model issuing status commands and queries
`timescale 1ns/1ns

module ser_host_model (
    input wire logic clk_sys,
    output ser_pkg::ser_cmd_t cmd
);
    // idle word at time zero so the block sees no command during reset
    initial begin
        cmd = '0;
    end

    // one command per call, launched after an edge, taken at the next one
    // released write, sel and data are inverted and valid and preset go low, so a stale value never looks valid
    task automatic issue(input logic wr, input logic pre,
            input logic [2:0] sel, input logic [15:0] data);
        @(posedge clk_sys);
        cmd <= '{valid: 1'b1, write: wr, preset: pre, sel: sel, data: data};
        @(posedge clk_sys);
        cmd <= '{valid: 1'b0, write: ~wr, preset: 1'b0, sel: ~sel,
                 data: ~data};
    endtask
endmodule

// >>> verif/tb_top.sv
// self-checking testbench for the status reporting registers
`timescale 1ns/1ns

module tb_top;
    logic clk_sys = 1'b0;
    logic arst_n;
    ser_pkg::ser_op_state_t op_state;
    ser_pkg::ser_qu_state_t qu_state;
    ser_pkg::ser_cmd_t cmd;
    logic resp_valid_r;
    logic [15:0] resp_data_r;
    logic oper_summary_r;
    logic ques_summary_r;
    int mismatches = 0;
    int n_tests = 0;

    // 25 MHz system clock
    always #20 clk_sys = ~clk_sys;

    ser_host_model host_u (.clk_sys(clk_sys), .cmd(cmd));

    ser_status_regs dut_u (
        .clk_sys(clk_sys), .arst_n(arst_n), .op_state(op_state),
        .qu_state(qu_state), .cmd(cmd), .resp_valid_r(resp_valid_r),
        .resp_data_r(resp_data_r), .oper_summary_r(oper_summary_r),
        .ques_summary_r(ques_summary_r)
    );

    // ****************************************
    // compare, verdict and bus helpers
    // ****************************************
    task automatic chk16(input string nm, input logic [15:0] e,
            input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // answer pulse lasts one cycle, so it is looked at just after it rises
    task automatic query(input logic [2:0] sel, output logic [15:0] d);
        host_u.issue(1'b0, 1'b0, sel, 16'h0000);
        #1;
        chk1("resp_valid", 1'b1, resp_valid_r);
        d = resp_data_r;
    endtask

    // status inputs pass a 2-flop sync, so allow sync plus latch time
    task automatic set_st(input logic [7:0] o, input logic [6:0] q);
        @(posedge clk_sys);
        op_state <= o;
        qu_state <= q;
        repeat (4) @(posedge clk_sys);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        logic [15:0] d;
        query(3'h1, d);
        chk16("op_ena_rst", 16'h0000, d);
        query(3'h4, d);
        chk16("qu_ena_rst", 16'h0000, d);
        chk1("oper_sum_rst", 1'b0, oper_summary_r);
        chk1("ques_sum_rst", 1'b0, ques_summary_r);
    endtask

    // walk one flag at a time; every rise must also be latched
    task automatic t_op_bits();
        int pos[8] = '{8, 10, 9, 11, 12, 14, 6, 5};
        logic [15:0] d;
        for (int i = 0; i < 8; i++) begin
            set_st(8'(8'h80 >> i), 7'h00);
            query(3'h0, d);
            chk16("op_cond", 16'h1 << pos[i], d);
        end
        set_st(8'h00, 7'h00);
        query(3'h2, d);
        chk16("op_evt", 16'h5F60, d);
        query(3'h2, d);
        chk16("op_evt_clr", 16'h0000, d);
    endtask

    task automatic t_qu_bits();
        int pos[7] = '{0, 1, 3, 6, 12, 13, 14};
        logic [15:0] d;
        for (int i = 0; i < 7; i++) begin
            set_st(8'h00, 7'(7'h40 >> i));
            query(3'h3, d);
            chk16("qu_cond", 16'h0001 << pos[i], d);
        end
        set_st(8'h00, 7'h60);
        query(3'h3, d);
        chk16("qu_cond_settle", 16'h0003, d);
        set_st(8'h00, 7'h00);
        query(3'h3, d);
        chk16("qu_cond_live", 16'h0000, d);
        query(3'h5, d);
        chk16("qu_evt", 16'h3000, d);
        query(3'h5, d);
        chk16("qu_evt_clr", 16'h0000, d);
    endtask

    // only enabled events may raise a summary; reading drops it again
    task automatic t_summary();
        logic [15:0] d;
        host_u.issue(1'b1, 1'b0, 3'h1, 16'h0400);
        host_u.issue(1'b1, 1'b0, 3'h4, 16'h1000);
        query(3'h1, d);
        chk16("op_ena", 16'h0400, d);
        query(3'h4, d);
        chk16("qu_ena", 16'h1000, d);
        set_st(8'h80, 7'h08);
        chk1("oper_sum_masked", 1'b0, oper_summary_r);
        chk1("ques_sum_masked", 1'b0, ques_summary_r);
        set_st(8'hC0, 7'h0C);
        chk1("oper_sum_set", 1'b1, oper_summary_r);
        chk1("ques_sum_set", 1'b1, ques_summary_r);
        query(3'h2, d);
        chk16("op_evt_two", 16'h0500, d);
        chk1("oper_sum_clr", 1'b0, oper_summary_r);
        query(3'h5, d);
        chk16("qu_evt_ve", 16'h1000, d);
        chk1("ques_sum_clr", 1'b0, ques_summary_r);
        set_st(8'h00, 7'h00);
    endtask

    // preset values, then a write to a read-only place and a spare code
    task automatic t_preset();
        logic [15:0] d;
        host_u.issue(1'b0, 1'b1, 3'h0, 16'h0000);
        query(3'h1, d);
        chk16("op_ena_preset", 16'h2001, d);
        query(3'h4, d);
        chk16("qu_ena_preset", 16'h00FF, d);
        host_u.issue(1'b1, 1'b0, 3'h2, 16'hFFFF);
        query(3'h2, d);
        chk16("op_evt_ro", 16'h0000, d);
        host_u.issue(1'b1, 1'b0, 3'h5, 16'hFFFF);
        query(3'h5, d);
        chk16("qu_evt_ro", 16'h0000, d);
        // preset and mask write in one command: preset must win
        host_u.issue(1'b1, 1'b0, 3'h4, 16'h1234);
        host_u.issue(1'b1, 1'b1, 3'h4, 16'h0F0F);
        query(3'h4, d);
        chk16("qu_ena_preset_wins", 16'h00FF, d);
        query(3'h6, d);
        chk16("spare_sel", 16'h0000, d);
    endtask

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        arst_n = 1'b0;
        op_state = '0;
        qu_state = '0;
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_reset();
        t_op_bits();
        t_qu_bits();
        t_summary();
        t_preset();
        wrap_up();
    end

    // whole run is a few hundred cycles; 5000 leaves wide margin
    initial begin
        #(40 * 5000);
        mismatches++;
        wrap_up();
    end
endmodule
